// ---- design/pef_pkg.sv ----
package pef_pkg;
	// ***********************************************
	// target address and register map
	// ***********************************************
	localparam logic [6:0] PEF_I2C_ADDR  = 7'h2A; // arbitrary value
	localparam logic [7:0] ADR_TOP_EVT   = 8'h01; // group summary, read only
	localparam logic [7:0] ADR_CHG_FLAG  = 8'h04; // charger_event_flags
	localparam logic [7:0] ADR_CHG_MASK  = 8'h05; // charger_event_mask
	localparam logic [7:0] ADR_RAIL_FLAG = 8'h06; // rail_event_flags
	localparam logic [7:0] ADR_RAIL_MASK = 8'h07; // rail_event_mask
	localparam logic [7:0] ADR_CTL0      = 8'h09; // power_path_control
	localparam logic [7:0] ADR_CTL1      = 8'h0A; // supply_threshold_control
	localparam logic [7:0] ADR_CTL2      = 8'h0B; // system_undervoltage_control
	// ***********************************************
	// reset values
	// ***********************************************
	localparam logic [7:0] RST_FLAG      = 8'h00;
	localparam logic [7:0] RST_CHG_MASK  = 8'h7F; // all events masked
	localparam logic [7:0] RST_RAIL_MASK = 8'hFF; // reserved upper bits reset to 1
	localparam logic [7:0] RST_CTL0      = 8'h41; // limit code 010, power-good on
	localparam logic [7:0] RST_CTL1      = 8'h89; // prewarn 10, auto source, uvlo 01
	localparam logic [7:0] RST_CTL2      = 8'hCE; // system uvlo 11
	// ***********************************************
	// field layout
	// ***********************************************
	localparam logic [7:0] CHG_EDGE_BITS   = 8'h78; // timers and limit: rising edge
	localparam logic [7:0] CHG_CHANGE_BITS = 8'h07; // status bits: any change
	localparam logic [7:0] CHG_FLAG_BITS   = 8'h7F; // bit 7 reads zero
	localparam logic [7:0] RAIL_FLAG_BITS  = 8'h0F; // bits 7:4 read zero
	localparam logic [7:0] RAIL_BUCK_BITS  = 8'h0C;
	localparam logic [7:0] RAIL_REG_BITS   = 8'h03;
	localparam int CHG_DEAD = 6, CHG_ILIM = 5, CHG_FAST = 4, CHG_PREQ = 3;
	localparam int CHG_BATT = 2, CHG_VBAT = 1, CHG_OKB = 0;
	localparam int CTL0_ILIM_HI = 7, CTL0_ILIM_LO = 5, CTL0_SHIP = 4;
	localparam int CTL0_PDN = 3, CTL0_WDSTOP = 2, CTL0_PGEN = 0;
	localparam int CTL1_PREW_HI = 7, CTL1_PREW_LO = 6, CTL1_SRC_HI = 5, CTL1_SRC_LO = 4;
	localparam int CTL1_OVP = 2, CTL1_UVLO_HI = 1, CTL1_UVLO_LO = 0;
	localparam int CTL2_SUVLO_HI = 7, CTL2_SUVLO_LO = 6;
	localparam int TOP_CHG = 2, TOP_BUCK = 1, TOP_REG = 0;
	localparam int PIN_SCL = 0, PIN_SDA = 1, PIN_KEY = 2, PIN_N = 3;
	localparam logic [3:0] BIT_FULL = 4'h8; // bits in one byte
	// ***********************************************
	// timing
	// ***********************************************
	localparam int CLK_PERIOD_NS   = 40;
	localparam int SYS_RST_HOLD_NS = 2000; // least width of system reset pulse
	localparam logic [7:0] SYS_RST_CYC =
		8'((SYS_RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	// ***********************************************
	// types
	// ***********************************************
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000, // bus not addressed
		ST_ADDR = 3'b001, // shifting address byte
		ST_REG  = 3'b010, // shifting register pointer
		ST_WR   = 3'b011, // shifting write data
		ST_ACK  = 3'b100, // driving acknowledge
		ST_RD   = 3'b101, // driving read data
		ST_MACK = 3'b110  // waiting for controller acknowledge
	} pef_state_t;
	typedef struct packed {
		logic dead_timer;   // dead charge timer expired
		logic ilim_active;  // input current limit engaged
		logic fast_timer;   // fast-charge timer expired
		logic preq_timer;   // pre-qualification timer expired
		logic battery_attached_status;
		logic battery_voltage_ok;
		logic charger_ok;
	} pef_chg_src_t;
	typedef struct packed {
		logic [2:0] input_current_limit_select;
		logic       ship_wake_select;
		logic       watchdog_charge_stop;
		logic       power_good_enable;
		logic [1:0] system_supply_prewarn;
		logic [1:0] system_supply_source;
		logic       input_overvoltage_select;
		logic [1:0] input_undervoltage_select;
		logic [1:0] system_undervoltage_select;
	} pef_cfg_t;
endpackage

// ---- design/pef_top.sv ----
`timescale 1ns/10ps
module pef_top
	import pef_pkg::*;
(
	// clock and reset
	input  wire logic         core_clk,
	input  wire logic         rst_b,
	// i2c target pins, open drain data
	input  wire logic         scl_in,
	input  wire logic         sda_in,
	output logic              sda_out,
	output logic              sda_oe,
	// on key pin, low when pressed
	input  wire logic         on_key_n_in,
	// event sources from the analog blocks
	input  wire pef_chg_src_t chg_src,
	input  wire logic [3:0]   rail_good_raw,
	input  wire logic         input_supply_valid,
	input  wire logic         watchdog_expired,
	// configuration and status
	output pef_cfg_t          cfg,
	output logic [3:0]        rail_good,
	// system controls
	output logic              irq_out_n,
	output logic              system_reset_out_n,
	output logic              charge_enable,
	output logic              rail_power_up,
	output logic              rails_to_mode0,
	output logic              power_down_start
);
	// ***********************************************
	// pin synchronisers
	// ***********************************************
	logic [PIN_N-1:0] pin_raw;   // scl, sda, key
	logic [PIN_N-1:0] pin_s1_q;  // first stage, read only by second
	logic [PIN_N-1:0] pin_s2_q;
	logic [PIN_N-1:0] pin_s3_q;
	logic [PIN_N-1:0] pin_f_q;   // filtered level
	logic [PIN_N-1:0] pin_fd_q;  // filtered level one cycle late
	assign pin_raw = {on_key_n_in, sda_in, scl_in};

	genvar gi;
	generate
		for (gi = 0; gi < PIN_N; gi++) begin : g_pin
			// idle level of all three pins is high
			always_ff @(posedge core_clk) begin
				if (!rst_b) begin
					pin_s1_q[gi] <= 1'b1;
					pin_s2_q[gi] <= 1'b1;
					pin_s3_q[gi] <= 1'b1;
					pin_f_q[gi]  <= 1'b1;
					pin_fd_q[gi] <= 1'b1;
				end else begin
					pin_s1_q[gi] <= pin_raw[gi];
					pin_s2_q[gi] <= pin_s1_q[gi];
					pin_s3_q[gi] <= pin_s2_q[gi];
					// a change counts only once two stages agree
					if (pin_s2_q[gi] == pin_s3_q[gi]) begin
						pin_f_q[gi] <= pin_s3_q[gi];
					end
					pin_fd_q[gi] <= pin_f_q[gi];
				end
			end
		end
	endgenerate

	// bus conditions from the filtered levels
	logic scl_rise;
	logic scl_fall;
	logic bus_start;
	logic bus_stop;
	logic key_fall;
	assign scl_rise  = pin_f_q[PIN_SCL] & ~pin_fd_q[PIN_SCL];
	assign scl_fall  = ~pin_f_q[PIN_SCL] & pin_fd_q[PIN_SCL];
	assign bus_start = pin_f_q[PIN_SCL] & pin_fd_q[PIN_SCL]
		& pin_fd_q[PIN_SDA] & ~pin_f_q[PIN_SDA];
	assign bus_stop  = pin_f_q[PIN_SCL] & pin_fd_q[PIN_SCL]
		& ~pin_fd_q[PIN_SDA] & pin_f_q[PIN_SDA];
	assign key_fall  = ~pin_f_q[PIN_KEY] & pin_fd_q[PIN_KEY];

	// ***********************************************
	// i2c target engine
	// ***********************************************
	pef_state_t state_q;    // protocol state
	logic [3:0] bit_cnt_q;  // bits seen in current byte
	logic [7:0] shift_q;    // byte being shifted
	logic [7:0] ptr_q;      // register pointer, auto increments
	logic       rd_q;       // current transfer is a read
	logic       have_ptr_q; // pointer byte already received
	logic       sda_oe_q;   // pulling the data line low
	logic       wr_stb_q;   // one-cycle register write
	logic [7:0] wr_adr_q;
	logic [7:0] wr_dat_q;
	logic [7:0] rd_data;    // register at pointer

	// the engine acts only on filtered scl edges and start/stop conditions, so glitches shorter
	// than two clocks never move it
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			state_q    <= ST_IDLE;
			bit_cnt_q  <= 4'h0;
			shift_q    <= 8'h00;
			ptr_q      <= 8'h00;
			rd_q       <= 1'b0;
			have_ptr_q <= 1'b0;
			sda_oe_q   <= 1'b0;
			wr_stb_q   <= 1'b0;
			wr_adr_q   <= 8'h00;
			wr_dat_q   <= 8'h00;
		end else begin
			wr_stb_q <= 1'b0;
			if (bus_start) begin
				// start or repeated start, pointer kept
				state_q    <= ST_ADDR;
				bit_cnt_q  <= 4'h0;
				have_ptr_q <= 1'b0;
				sda_oe_q   <= 1'b0;
			end else if (bus_stop) begin
				state_q  <= ST_IDLE;
				sda_oe_q <= 1'b0;
			end else if (scl_rise) begin
				case (state_q)
					ST_ADDR, ST_REG, ST_WR: begin
						shift_q   <= {shift_q[6:0], pin_f_q[PIN_SDA]};
						bit_cnt_q <= bit_cnt_q + 4'h1;
					end
					ST_RD: begin
						bit_cnt_q <= bit_cnt_q + 4'h1;
					end
					ST_MACK: begin
						// controller nack ends the read
						if (pin_f_q[PIN_SDA]) begin
							state_q <= ST_IDLE;
						end
					end
					default: begin
					end
				endcase
			end else if (scl_fall) begin
				case (state_q)
					ST_ADDR: begin
						if (bit_cnt_q == BIT_FULL) begin
							if (shift_q[7:1] == PEF_I2C_ADDR) begin
								rd_q     <= shift_q[0];
								sda_oe_q <= 1'b1;
								state_q  <= ST_ACK;
							end else begin
								state_q <= ST_IDLE;
							end
						end
					end
					ST_REG: begin
						if (bit_cnt_q == BIT_FULL) begin
							ptr_q      <= shift_q;
							have_ptr_q <= 1'b1;
							sda_oe_q   <= 1'b1;
							state_q    <= ST_ACK;
						end
					end
					ST_WR: begin
						if (bit_cnt_q == BIT_FULL) begin
							wr_stb_q <= 1'b1;
							wr_adr_q <= ptr_q;
							wr_dat_q <= shift_q;
							ptr_q    <= ptr_q + 8'h01;
							sda_oe_q <= 1'b1;
							state_q  <= ST_ACK;
						end
					end
					ST_ACK: begin
						bit_cnt_q <= 4'h0;
						if (rd_q) begin
							shift_q  <= rd_data;
							sda_oe_q <= ~rd_data[7];
							state_q  <= ST_RD;
						end else begin
							sda_oe_q <= 1'b0;
							state_q  <= have_ptr_q ? ST_WR : ST_REG;
						end
					end
					ST_RD: begin
						if (bit_cnt_q == BIT_FULL) begin
							// release the line for the controller acknowledge
							sda_oe_q <= 1'b0;
							ptr_q    <= ptr_q + 8'h01;
							state_q  <= ST_MACK;
						end else begin
							sda_oe_q <= ~shift_q[3'(4'h7 - bit_cnt_q)];
						end
					end
					ST_MACK: begin
						bit_cnt_q <= 4'h0;
						shift_q   <= rd_data;
						sda_oe_q  <= ~rd_data[7];
						state_q   <= ST_RD;
					end
					default: begin
					end
				endcase
			end
		end
	end

	assign sda_out = 1'b0;
	assign sda_oe  = sda_oe_q;

	// ***********************************************
	// configuration registers
	// ***********************************************
	logic [7:0] chg_mask_q;  // charger_event_mask
	logic [7:0] rail_mask_q; // rail_event_mask
	logic [7:0] ctl0_q;      // power_path_control
	logic [7:0] ctl1_q;      // supply_threshold_control
	logic [7:0] ctl2_q;      // system_undervoltage_control

	// plain read/write storage, reserved bits kept as written
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			chg_mask_q  <= RST_CHG_MASK;
			rail_mask_q <= RST_RAIL_MASK;
			ctl0_q      <= RST_CTL0;
			ctl1_q      <= RST_CTL1;
			ctl2_q      <= RST_CTL2;
		end else if (wr_stb_q) begin
			case (wr_adr_q)
				ADR_CHG_MASK:  chg_mask_q  <= wr_dat_q;
				ADR_RAIL_MASK: rail_mask_q <= wr_dat_q;
				ADR_CTL0:      ctl0_q      <= wr_dat_q;
				ADR_CTL1:      ctl1_q      <= wr_dat_q;
				ADR_CTL2:      ctl2_q      <= wr_dat_q;
				default: begin
				end
			endcase
		end
	end

	// field view for the analog side; codes pass through untouched
	always_comb begin
		cfg.input_current_limit_select = ctl0_q[CTL0_ILIM_HI:CTL0_ILIM_LO];
		cfg.ship_wake_select           = ctl0_q[CTL0_SHIP];
		cfg.watchdog_charge_stop       = ctl0_q[CTL0_WDSTOP];
		cfg.power_good_enable          = ctl0_q[CTL0_PGEN];
		cfg.system_supply_prewarn      = ctl1_q[CTL1_PREW_HI:CTL1_PREW_LO];
		cfg.system_supply_source       = ctl1_q[CTL1_SRC_HI:CTL1_SRC_LO];
		cfg.input_overvoltage_select   = ctl1_q[CTL1_OVP];
		cfg.input_undervoltage_select  = ctl1_q[CTL1_UVLO_HI:CTL1_UVLO_LO];
		cfg.system_undervoltage_select = ctl2_q[CTL2_SUVLO_HI:CTL2_SUVLO_LO];
	end

	// comparators disabled force every status bit low
	assign rail_good = ctl0_q[CTL0_PGEN] ? rail_good_raw : 4'h0;

	// ***********************************************
	// event flags
	// ***********************************************
	logic [7:0] chg_src_v;   // sources in flag bit order
	logic [7:0] chg_prev_q;  // sources one cycle late
	logic [7:0] rail_src_v;
	logic [7:0] rail_prev_q;
	logic [7:0] chg_set;     // flag set this cycle
	logic [7:0] rail_set;
	logic [7:0] chg_clr;     // flag cleared by host this cycle
	logic [7:0] rail_clr;
	logic [7:0] chg_flag_q;  // charger_event_flags
	logic [7:0] rail_flag_q; // rail_event_flags
	assign chg_src_v  = {1'b0, chg_src};
	assign rail_src_v = {4'h0, rail_good};
	assign chg_set = ((chg_src_v & ~chg_prev_q) & CHG_EDGE_BITS)
		| ((chg_src_v ^ chg_prev_q) & CHG_CHANGE_BITS);
	assign rail_set = (rail_src_v ^ rail_prev_q) & RAIL_FLAG_BITS;
	// reading never clears; only a write of ones does
	assign chg_clr  = (wr_stb_q && wr_adr_q == ADR_CHG_FLAG) ? wr_dat_q : 8'h00;
	assign rail_clr = (wr_stb_q && wr_adr_q == ADR_RAIL_FLAG) ? wr_dat_q : 8'h00;

	// set is ored after the clear so a fresh event is never lost
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			chg_prev_q  <= RST_FLAG;
			rail_prev_q <= RST_FLAG;
			chg_flag_q  <= RST_FLAG;
			rail_flag_q <= RST_FLAG;
		end else begin
			chg_prev_q  <= chg_src_v;
			rail_prev_q <= rail_src_v;
			chg_flag_q  <= (chg_flag_q & ~chg_clr) | chg_set;
			rail_flag_q <= (rail_flag_q & ~rail_clr) | rail_set;
		end
	end

	// ***********************************************
	// group summaries and interrupt
	// ***********************************************
	logic [7:0] top_evt;  // read view of summary register
	logic       sum_any;
	assign top_evt[7:3]    = 5'h00;
	assign top_evt[TOP_CHG]  = |(chg_flag_q & ~chg_mask_q & CHG_FLAG_BITS);
	assign top_evt[TOP_BUCK] = |(rail_flag_q & ~rail_mask_q & RAIL_BUCK_BITS);
	assign top_evt[TOP_REG]  = |(rail_flag_q & ~rail_mask_q & RAIL_REG_BITS);
	assign sum_any = |top_evt;

	// level interrupt: further events while pending give no new edge
	logic irq_n_q;
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			irq_n_q <= 1'b1;
		end else begin
			irq_n_q <= ~sum_any;
		end
	end
	assign irq_out_n = irq_n_q;

	// ***********************************************
	// read mux
	// ***********************************************
	always_comb begin
		case (ptr_q)
			ADR_TOP_EVT:   rd_data = top_evt;
			ADR_CHG_FLAG:  rd_data = chg_flag_q & CHG_FLAG_BITS;
			ADR_CHG_MASK:  rd_data = chg_mask_q;
			ADR_RAIL_FLAG: rd_data = rail_flag_q & RAIL_FLAG_BITS;
			ADR_RAIL_MASK: rd_data = rail_mask_q;
			ADR_CTL0:      rd_data = ctl0_q;
			ADR_CTL1:      rd_data = ctl1_q;
			ADR_CTL2:      rd_data = ctl2_q;
			default:       rd_data = 8'h00;
		endcase
	end

	// ***********************************************
	// power sequencing requests
	// ***********************************************
	logic       in_prev_q;   // input supply one cycle late
	logic       in_rise;
	logic       pd_start;    // host wrote power-down with bit set
	logic       pd_lock_q;   // rails off via power-down bit
	logic       pwr_up_q;
	logic       pd_q;
	logic       chg_en_q;
	logic       mode0_q;
	logic [7:0] rst_cnt_q;   // system reset hold counter
	logic       sys_n_q;
	assign in_rise  = input_supply_valid & ~in_prev_q;
	assign pd_start = wr_stb_q && wr_adr_q == ADR_CTL0 && wr_dat_q[CTL0_PDN];

	// plug-in (ship wake off) or key press (ship wake on) requests rail power-up; the power-down lock
	// blocks only the input path, so the key remains a way out
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			in_prev_q <= 1'b0;
			pd_lock_q <= 1'b0;
			pwr_up_q  <= 1'b0;
			pd_q      <= 1'b0;
		end else begin
			in_prev_q <= input_supply_valid;
			pd_q      <= pd_start;
			pwr_up_q  <= (in_rise & ~ctl0_q[CTL0_SHIP] & ~pd_lock_q)
				| (key_fall & ctl0_q[CTL0_SHIP]);
			if (pd_start) begin
				pd_lock_q <= 1'b1;
			end else if (key_fall & ctl0_q[CTL0_SHIP]) begin
				pd_lock_q <= 1'b0;
			end
		end
	end

	// charging follows plug-in in both wake modes
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			chg_en_q  <= 1'b0;
			mode0_q   <= 1'b0;
			rst_cnt_q <= 8'h00;
			sys_n_q   <= 1'b1;
		end else begin
			mode0_q <= watchdog_expired;
			if (watchdog_expired && ctl0_q[CTL0_WDSTOP]) begin
				chg_en_q <= 1'b0;
			end else if (in_rise) begin
				chg_en_q <= 1'b1;
			end else if (!input_supply_valid) begin
				chg_en_q <= 1'b0;
			end
			if (watchdog_expired) begin
				rst_cnt_q <= SYS_RST_CYC;
			end else if (rst_cnt_q != 8'h00) begin
				rst_cnt_q <= rst_cnt_q - 8'h01;
			end
			sys_n_q <= ~(watchdog_expired | (rst_cnt_q > 8'h01));
		end
	end
	assign rail_power_up      = pwr_up_q;
	assign power_down_start   = pd_q;
	assign charge_enable      = chg_en_q;
	assign rails_to_mode0     = mode0_q;
	assign system_reset_out_n = sys_n_q;

	// ***********************************************
	// checks
	// ***********************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	// a host clear one cycle after the event may legally drop the flag
	property p_dead_latch;
		$rose(chg_src.dead_timer) |=> chg_flag_q[CHG_DEAD]
			##1 (chg_flag_q[CHG_DEAD] || $past(chg_clr[CHG_DEAD]));
	endproperty
	a_dead_latch: assert property (p_dead_latch) else $error("dead flag lost");
	property p_ilim_latch;
		$rose(chg_src.ilim_active) |=> chg_flag_q[CHG_ILIM];
	endproperty
	a_ilim_latch: assert property (p_ilim_latch) else $error("limit flag lost");
	property p_fast_latch;
		$rose(chg_src.fast_timer) |=> chg_flag_q[CHG_FAST];
	endproperty
	a_fast_latch: assert property (p_fast_latch) else $error("fast flag lost");
	property p_preq_latch;
		$rose(chg_src.preq_timer) |=> chg_flag_q[CHG_PREQ];
	endproperty
	a_preq_latch: assert property (p_preq_latch) else $error("prequal flag lost");
	property p_status_change;
		$changed(chg_src.battery_voltage_ok) |=> chg_flag_q[CHG_VBAT];
	endproperty
	a_status_change: assert property (p_status_change) else $error("status flag lost");
	property p_hold_until_write;
		chg_flag_q[CHG_OKB] && !chg_clr[CHG_OKB] |=> chg_flag_q[CHG_OKB];
	endproperty
	a_hold_until_write: assert property (p_hold_until_write) else $error("flag dropped");
	// any bit set and cleared in one cycle must read back set
	property p_set_beats_clear;
		(chg_set & chg_clr) != 8'h00
			|=> (chg_flag_q & $past(chg_set & chg_clr)) == $past(chg_set & chg_clr);
	endproperty
	a_set_beats_clear: assert property (p_set_beats_clear) else $error("set lost");
	property p_rail_latch;
		$changed(rail_good[3]) |=> rail_flag_q[3];
	endproperty
	a_rail_latch: assert property (p_rail_latch) else $error("rail flag lost");
	property p_masked_rail;
		(rail_mask_q & RAIL_FLAG_BITS) == RAIL_FLAG_BITS |-> !top_evt[TOP_BUCK] && !top_evt[TOP_REG];
	endproperty
	a_masked_rail: assert property (p_masked_rail) else $error("masked event shown");
	property p_irq_follows;
		sum_any |=> !irq_out_n;
	endproperty
	a_irq_follows: assert property (p_irq_follows) else $error("interrupt missing");
	property p_pg_gate;
		!ctl0_q[CTL0_PGEN] |-> rail_good == 4'h0;
	endproperty
	a_pg_gate: assert property (p_pg_gate) else $error("status not forced low");
	sequence s_wd_reset;
		!system_reset_out_n [*8];
	endsequence
	property p_watchdog;
		watchdog_expired |=> s_wd_reset;
	endproperty
	a_watchdog: assert property (p_watchdog) else $error("system reset too short");
	property p_input_blocked;
		pd_lock_q && !ctl0_q[CTL0_SHIP] |=> !rail_power_up;
	endproperty
	a_input_blocked: assert property (p_input_blocked) else $error("power-up after lock");
endmodule

// ---- tb/pef_host.sv ----
`timescale 1ns/10ps
// ****************
// i2c controller model
// ****************
module pef_host
	import pef_pkg::*;
(
	// clock and device pull
	input  wire logic core_clk,
	input  wire logic sda_oe,
	// bus lines
	output logic      scl,
	output logic      sda
);
	logic sda_low; // host pulls data low
	int   nacks;   // acknowledges not seen
	// pull-up: high unless someone pulls
	assign sda = ~(sda_low | sda_oe);
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
		nacks = 0;
	end
	// half period well above the pin filter
	task automatic hp;
		repeat (10) @(posedge core_clk);
	endtask
	// one bit; data moves only while scl is low
	task automatic bx(input logic b, output logic r);
		hp;
		sda_low <= ~b;
		hp;
		scl <= 1'b1;
		hp;
		r = sda;
		scl <= 1'b0;
	endtask
	// start (or repeated start) and stop
	task automatic st(input logic stop);
		hp;
		sda_low <= stop;
		hp;
		scl <= 1'b1;
		hp;
		sda_low <= ~stop;
		hp;
		// a start hands the clock low for the first bit, a stop leaves it high
		scl <= stop;
	endtask
	task automatic tx(input logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) bx(d[i], r);
		bx(1'b1, r);
		if (r) nacks++;
	endtask
	// writing 1s acknowledges flags
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		st(1'b0);
		tx({PEF_I2C_ADDR, 1'b0});
		tx(a);
		tx(d);
		st(1'b1);
	endtask
	// single byte read ended by a nack
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		logic r;
		st(1'b0);
		tx({PEF_I2C_ADDR, 1'b0});
		tx(a);
		st(1'b0);
		tx({PEF_I2C_ADDR, 1'b1});
		for (int i = 7; i >= 0; i--) bx(1'b1, d[i]);
		bx(1'b1, r);
		st(1'b1);
	endtask
endmodule

// ---- tb/pef_top_bench.sv ----
`timescale 1ns/10ps
// ****************
// register and event bench
// ****************
module pef_top_bench import pef_pkg::*; ;
	logic core_clk, rst_b, scl, sda, sda_oe, key_n, input_supply, wdog;
	logic irq_n, sys_rst_n, chg_en, pup, mode0, pdn;
	pef_chg_src_t chg;       // charger sources
	pef_cfg_t     cfg;       // decoded settings
	logic [3:0]   raw, good; // rail power-good in/out
	logic [7:0]   v;
	int miscompares, check_count, n_pup, n_m0, n_pdn;
	logic [7:0] ra[8] = '{ADR_CHG_FLAG, ADR_CHG_MASK, ADR_RAIL_FLAG, ADR_RAIL_MASK,
		ADR_CTL0, ADR_CTL1, ADR_CTL2, 8'h08};
	logic [7:0] rv[8] = '{8'h00, 8'h7F, 8'h00, 8'hFF, 8'h41, 8'h89, 8'hCE, 8'h00};
	pef_host u_host (.core_clk(core_clk), .sda_oe(sda_oe), .scl(scl), .sda(sda));
	pef_top u_dut (.core_clk(core_clk), .rst_b(rst_b), .scl_in(scl), .sda_in(sda),
		.sda_out(), .sda_oe(sda_oe), .on_key_n_in(key_n), .chg_src(chg),
		.rail_good_raw(raw), .input_supply_valid(input_supply), .watchdog_expired(wdog),
		.cfg(cfg), .rail_good(good), .irq_out_n(irq_n), .system_reset_out_n(sys_rst_n),
		.charge_enable(chg_en), .rail_power_up(pup), .rails_to_mode0(mode0),
		.power_down_start(pdn));
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end
	// pulse counters
	always @(posedge core_clk) begin
		n_pup += pup;
		n_m0 += mode0;
		n_pdn += pdn;
	end
	task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
		check_count++;
		if (s !== e) begin
			miscompares++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic rc(input logic [7:0] a, input logic [7:0] e);
		u_host.rd(a, v);
		chk($sformatf("reg %h", a), v, e);
	endtask
	task automatic w(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	task automatic results;
		$display("checks %0d miscompares %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		w(60000);
		miscompares++;
		results;
	end
	initial begin
		{rst_b, key_n, input_supply, wdog, chg, raw} = {1'b0, 1'b1, 13'h0000};
		{miscompares, check_count, n_pup, n_m0, n_pdn} = '0;
		w(8);
		rst_b <= 1'b1;
		w(8);
		for (int i = 0; i < 8; i++) rc(ra[i], rv[i]);
		chk("ilim", {5'h00, cfg.input_current_limit_select}, 8'h02);
		chg <= '1;
		w(4);
		rc(ADR_CHG_FLAG, 8'h7F);
		rc(ADR_CHG_FLAG, 8'h7F);
		rc(ADR_TOP_EVT, 8'h00);
		u_host.wr(ADR_CHG_MASK, 8'h00);
		w(3);
		chk("irq", {7'h00, irq_n}, 8'h00);
		rc(ADR_TOP_EVT, 8'h04);
		// status bit 0 keeps changing up to the clear strobe; the strobe is
		// read before the edge moves it, so the last change meets the clear
		fork
			u_host.wr(ADR_CHG_FLAG, 8'h7F);
			while (!u_dut.wr_stb_q) begin
				@(posedge core_clk);
				if (!u_dut.wr_stb_q) chg.charger_ok <= ~chg.charger_ok;
			end
		join
		rc(ADR_CHG_FLAG, 8'h01);
		u_host.wr(ADR_CHG_FLAG, 8'h01);
		rc(ADR_CHG_FLAG, 8'h00);
		rc(ADR_TOP_EVT, 8'h00);
		chk("irq", {7'h00, irq_n}, 8'h01);
		u_host.wr(ADR_RAIL_MASK, 8'h07);
		rc(ADR_RAIL_MASK, 8'h07);
		raw <= 4'h9;
		w(4);
		rc(ADR_RAIL_FLAG, 8'h09);
		rc(ADR_TOP_EVT, 8'h02);
		u_host.wr(ADR_RAIL_FLAG, 8'h08);
		rc(ADR_RAIL_FLAG, 8'h01);
		rc(ADR_TOP_EVT, 8'h00);
		input_supply <= 1'b1;
		w(3);
		chk("power up", {n_pup[6:0], chg_en}, 8'h03);
		u_host.wr(ADR_CTL0, 8'h45);
		wdog <= 1'b1;
		w(1);
		wdog <= 1'b0;
		w(2);
		chk("watchdog", {n_m0[5:0], sys_rst_n, chg_en}, 8'h04);
		u_host.wr(ADR_CTL0, 8'h40);
		chk("good", {4'h0, good}, 8'h00);
		u_host.wr(ADR_CTL0, 8'h48);
		input_supply <= 1'b0;
		w(3);
		input_supply <= 1'b1;
		w(3);
		chk("power down", {n_pdn[3:0], n_pup[3:0]}, 8'h11);
		// ship wake: plug-in charges only, the key brings the rails up
		u_host.wr(ADR_CTL0, 8'h51);
		input_supply <= 1'b0;
		w(3);
		input_supply <= 1'b1;
		w(3);
		chk("ship plug", {n_pup[6:0], chg_en}, 8'h03);
		key_n <= 1'b0;
		w(8);
		key_n <= 1'b1;
		w(2);
		chk("ship key", {n_pdn[3:0], n_pup[3:0]}, 8'h12);
		// watchdog with charging kept on
		wdog <= 1'b1;
		w(1);
		wdog <= 1'b0;
		w(2);
		chk("watchdog keep", {n_m0[5:0], sys_rst_n, chg_en}, 8'h09);
		w(60);
		chk("reset release", {7'h00, sys_rst_n}, 8'h01);
		chk("nacks", u_host.nacks[7:0], 8'h00);
		results;
	end
endmodule
